// ==== verilog/exec_map.vh ====
// Constants for the branch and load/store execution unit
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH

// APB register byte offsets
`define OFS_INSN     8'h00
`define OFS_INSN2    8'h04
`define OFS_PC       8'h08
`define OFS_FLAGS    8'h0c
`define OFS_STATUS   8'h10
`define OFS_REGSEL   8'h14
`define OFS_REGDATA  8'h18

// Reset values
`define RST_PC       16'h0000
`define RST_FLAGS    8'h00

// Flag register bit positions
`define FLG_C        3'h0
`define FLG_Z        3'h1
`define FLG_N        3'h2
`define FLG_V        3'h3
`define FLG_S        3'h4
`define FLG_H        3'h5
`define FLG_T        3'h6
`define FLG_I        3'h7

// Instruction classes in bits 15:12
`define CLS_BRANCH   4'h0
`define CLS_COPY     4'h1
`define CLS_PAIR     4'h2
`define CLS_CONST    4'h3
`define CLS_PREAD    4'h4
`define CLS_PWRITE   4'h5
`define CLS_OREAD    4'h6
`define CLS_OWRITE   4'h7
`define CLS_AREAD    4'h8
`define CLS_AWRITE   4'h9
`define CLS_CODE     4'ha

// Pointer addressing modes
`define PM_PLAIN     2'h0
`define PM_POSTINC   2'h1
`define PM_PREDEC    2'h2

// Pointer selects
`define PTR_X        2'h0
`define PTR_Y        2'h1
`define PTR_Z        2'h2

// Status bit positions
`define ST_BUSY      0
`define ST_CYC_LO    1
`define ST_CYC_HI    2
`define ST_TAKEN     3
`define ST_ILLEGAL   4

// Execution times in cycles
`define CYC_ONE      2'h1
`define CYC_TWO      2'h2
`define CYC_THREE    2'h3

`endif

// ==== verilog/cond_branch_and_load_store.v ====
// Branch, move and data load/store execution unit with APB access
//
// Functional notes
// - Flag-set branch jumps to pc plus offset plus one
// - Flag-clear branch jumps when selected bit zero
// - Equal/not-equal branches test zero flag
// - Carry-set/lower and carry-clear/higher test carry
// - Same-or-higher uses carry-clear condition
// - Negative/positive branches test negative flag
// - Signed ge jumps when N xor V zero
// - Signed less jumps when N xor V one
// - Half-carry branches test half-carry flag
// - User-bit branches test transfer flag
// - Interrupt branches test global enable flag
// - Moves and constant load: one cycle, no flags
// - Pointer read two cycles, optional post-increment
// - Pre-decrement read decrements pointer first
// - Offset read uses Y/Z plus displacement
// - Absolute read from address word, two cycles
// - Pointer write two cycles, optional post-increment
// - Pre-decrement write decrements pointer first
// - Offset write uses Y/Z plus displacement
// - Absolute write to address word, two cycles
// - Code space read via Z, three cycles
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`include "exec_map.vh"

module cond_branch_and_load_store #(
    parameter ADDR_W = 16
) (
    input  wire              MCLK,
    input  wire              NRST,
    input  wire              PSEL,
    input  wire              PENABLE,
    input  wire              PWRITE,
    input  wire [7:0]        PADDR,
    input  wire [31:0]       PWDATA,
    output reg  [31:0]       PRDATA,
    output reg               PREADY,
    output reg               PSLVERR,
    output reg  [ADDR_W-1:0] DM_ADDR,
    output reg  [7:0]        DM_WDATA,
    output reg               DM_WE,
    output reg               DM_RE,
    input  wire [7:0]        DM_RDATA,
    output reg  [ADDR_W-1:0] PM_ADDR,
    output reg               PM_RE,
    input  wire [7:0]        PM_RDATA,
    output reg               BUSY
);

////////////////////////////////////////////////////////////////////////
// State encoding

localparam S_IDLE = 2'h0;
localparam S_C1   = 2'h1;
localparam S_C2   = 2'h2;
localparam S_C3   = 2'h3;

////////////////////////////////////////////////////////////////////////
// Storage

reg  [7:0]        regs [0:31];
reg  [15:0]       ir_r;
reg  [15:0]       ir2_r;
reg  [15:0]       pc_r;
reg  [15:0]       pcn_r;
reg  [7:0]        flags_r;
reg  [1:0]        state_r;
reg  [1:0]        cyc_r;
reg  [1:0]        last_cyc_r;
reg               taken_r;
reg               illegal_r;
reg  [4:0]        regsel_r;
reg  [4:0]        dst_r;
integer           i;

////////////////////////////////////////////////////////////////////////
// Field decode

wire [3:0]        cls     = ir_r[15:12];
wire              b_sense = ir_r[11];
wire [2:0]        b_bit   = ir_r[10:8];
wire [6:0]        b_off   = ir_r[6:0];
wire [4:0]        f_d     = ir_r[4:0];
wire [4:0]        f_cr    = ir_r[9:5];
wire [3:0]        f_pd    = ir_r[7:4];
wire [3:0]        f_pr    = ir_r[3:0];
wire [3:0]        f_kd    = ir_r[11:8];
wire [7:0]        f_k     = ir_r[7:0];
wire [1:0]        f_psel  = ir_r[11:10];
wire [1:0]        f_pmode = ir_r[9:8];
wire              f_osel  = ir_r[11];
wire [5:0]        f_q     = ir_r[10:5];
wire              f_cinc  = ir_r[8];

////////////////////////////////////////////////////////////////////////
// Helper functions

// Condition of a flag-test branch; bit S is formed as N xor V
function cond_true;
    input [2:0] sbit;
    input       sense;
    input [7:0] fl;
    reg         v;
    begin
        v = fl[sbit];
        if (sbit == `FLG_S) begin
            v = fl[`FLG_N] ^ fl[`FLG_V];
        end
        cond_true = sense ? v : ~v;
    end
endfunction

// Low register index of a pointer pair
function [4:0] ptr_base;
    input [1:0] sel;
    reg   [1:0] s1;
    begin
        s1 = sel + 2'h1;
        ptr_base = {2'b11, s1, 1'b0};
    end
endfunction

// True when an APB write must be refused because an instruction is executing
function busy_block;
    input [1:0] st;
    begin
        busy_block = (st != S_IDLE);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Operand paths

wire [4:0]        pb     = ptr_base(f_psel);
wire [15:0]       pval   = {regs[pb + 5'h1], regs[pb]};
wire [4:0]        ob     = ptr_base(f_osel ? `PTR_Z : `PTR_Y);
wire [15:0]       oval   = {regs[ob + 5'h1], regs[ob]};
wire [4:0]        zb     = ptr_base(`PTR_Z);
wire [15:0]       zval   = {regs[zb + 5'h1], regs[zb]};
wire [15:0]       pinc   = pval + 16'h0001;
wire [15:0]       pdec   = pval - 16'h0001;
wire [15:0]       zinc   = zval + 16'h0001;
wire [15:0]       oaddr  = oval + {10'h000, f_q};
wire [15:0]       boff   = {{9{b_off[6]}}, b_off};
wire [15:0]       btgt   = pc_r + boff + 16'h0001;
wire              ptr_ok = (f_psel != 2'h3) && (f_pmode != 2'h3);
wire              take   = cond_true(b_bit, b_sense, flags_r);
wire [15:0]       paddr  = (f_pmode == `PM_PREDEC) ? pdec : pval;

////////////////////////////////////////////////////////////////////////
// APB decode

wire              acc1   = PSEL & PENABLE & ~PREADY;
wire              acc2   = PSEL & PENABLE & PREADY;
wire              wr_go  = acc2 & PWRITE & ~PSLVERR;
wire              mapped = (PADDR == `OFS_INSN)   || (PADDR == `OFS_INSN2) ||
                           (PADDR == `OFS_PC)     || (PADDR == `OFS_FLAGS) ||
                           (PADDR == `OFS_STATUS) || (PADDR == `OFS_REGSEL) ||
                           (PADDR == `OFS_REGDATA);
wire              ro_hit = (PADDR == `OFS_STATUS);
wire              wr_err = PWRITE & (ro_hit | busy_block(state_r));

reg  [31:0]       rd_nxt;

always @* begin
    rd_nxt = 32'h0000_0000;
    case (PADDR)
        `OFS_INSN:    rd_nxt = {16'h0000, ir_r};
        `OFS_INSN2:   rd_nxt = {16'h0000, ir2_r};
        `OFS_PC:      rd_nxt = {16'h0000, pc_r};
        `OFS_FLAGS:   rd_nxt = {24'h000000, flags_r};
        `OFS_STATUS:  rd_nxt = {27'h0000000, illegal_r, taken_r, last_cyc_r, BUSY};
        `OFS_REGSEL:  rd_nxt = {27'h0000000, regsel_r};
        `OFS_REGDATA: rd_nxt = {24'h000000, regs[regsel_r]};
        default:      rd_nxt = 32'h0000_0000;
    endcase
end

////////////////////////////////////////////////////////////////////////
// Bus slave and execution sequencer

always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
        PRDATA     <= 32'h0000_0000;
        PREADY     <= 1'b0;
        PSLVERR    <= 1'b0;
        DM_ADDR    <= 16'h0000;
        DM_WDATA   <= 8'h00;
        DM_WE      <= 1'b0;
        DM_RE      <= 1'b0;
        PM_ADDR    <= 16'h0000;
        PM_RE      <= 1'b0;
        BUSY       <= 1'b0;
        ir_r       <= 16'h0000;
        ir2_r      <= 16'h0000;
        pc_r       <= `RST_PC;
        pcn_r      <= `RST_PC;
        flags_r    <= `RST_FLAGS;
        state_r    <= S_IDLE;
        cyc_r      <= 2'h0;
        last_cyc_r <= 2'h0;
        taken_r    <= 1'b0;
        illegal_r  <= 1'b0;
        regsel_r   <= 5'h00;
        dst_r      <= 5'h00;
        for (i = 0; i < 32; i = i + 1) begin
            regs[i] <= 8'h00;
        end
    end else begin
        // Two-cycle access phase: data and error ready on the second
        PREADY <= acc1;
        if (acc1) begin
            PRDATA  <= PWRITE ? 32'h0000_0000 : rd_nxt;
            PSLVERR <= ~mapped | wr_err;
        end else if (!PSEL) begin
            PSLVERR <= 1'b0;
        end

        if (wr_go) begin
            case (PADDR)
                `OFS_INSN: begin
                    ir_r      <= PWDATA[15:0];
                    state_r   <= S_C1;
                    BUSY      <= 1'b1;
                    cyc_r     <= 2'h0;
                    taken_r   <= 1'b0;
                    illegal_r <= 1'b0;
                end
                `OFS_INSN2:   ir2_r    <= PWDATA[15:0];
                `OFS_PC:      pc_r     <= PWDATA[15:0];
                `OFS_FLAGS:   flags_r  <= PWDATA[7:0];
                `OFS_REGSEL:  regsel_r <= PWDATA[4:0];
                `OFS_REGDATA: regs[regsel_r] <= PWDATA[7:0];
                default: begin
                end
            endcase
        end

        case (state_r)
            S_C1: begin
                cyc_r <= cyc_r + 2'h1;
                pcn_r <= pc_r + 16'h0001;
                case (cls)
                    `CLS_BRANCH: begin
                        if (take) begin
                            pcn_r   <= btgt;
                            taken_r <= 1'b1;
                            state_r <= S_C2;
                        end else begin
                            pc_r       <= pc_r + 16'h0001;
                            state_r    <= S_IDLE;
                            BUSY       <= 1'b0;
                            last_cyc_r <= `CYC_ONE;
                        end
                    end
                    `CLS_COPY: begin
                        regs[f_cr] <= regs[f_d];
                        pc_r       <= pc_r + 16'h0001;
                        state_r    <= S_IDLE;
                        BUSY       <= 1'b0;
                        last_cyc_r <= `CYC_ONE;
                    end
                    `CLS_PAIR: begin
                        regs[{f_pd, 1'b0}] <= regs[{f_pr, 1'b0}];
                        regs[{f_pd, 1'b1}] <= regs[{f_pr, 1'b1}];
                        pc_r       <= pc_r + 16'h0001;
                        state_r    <= S_IDLE;
                        BUSY       <= 1'b0;
                        last_cyc_r <= `CYC_ONE;
                    end
                    `CLS_CONST: begin
                        regs[{1'b1, f_kd}] <= f_k;
                        pc_r       <= pc_r + 16'h0001;
                        state_r    <= S_IDLE;
                        BUSY       <= 1'b0;
                        last_cyc_r <= `CYC_ONE;
                    end
                    `CLS_PREAD, `CLS_PWRITE: begin
                        if (ptr_ok) begin
                            DM_ADDR <= paddr;
                            dst_r   <= f_d;
                            if (cls == `CLS_PWRITE) begin
                                DM_WDATA <= regs[f_d];
                                DM_WE    <= 1'b1;
                            end else begin
                                DM_RE    <= 1'b1;
                            end
                            if (f_pmode == `PM_POSTINC) begin
                                regs[pb]        <= pinc[7:0];
                                regs[pb + 5'h1] <= pinc[15:8];
                            end else if (f_pmode == `PM_PREDEC) begin
                                regs[pb]        <= pdec[7:0];
                                regs[pb + 5'h1] <= pdec[15:8];
                            end
                            state_r <= S_C2;
                        end else begin
                            illegal_r  <= 1'b1;
                            pc_r       <= pc_r + 16'h0001;
                            state_r    <= S_IDLE;
                            BUSY       <= 1'b0;
                            last_cyc_r <= `CYC_ONE;
                        end
                    end
                    `CLS_OREAD, `CLS_OWRITE: begin
                        DM_ADDR <= oaddr;
                        dst_r   <= f_d;
                        if (cls == `CLS_OWRITE) begin
                            DM_WDATA <= regs[f_d];
                            DM_WE    <= 1'b1;
                        end else begin
                            DM_RE    <= 1'b1;
                        end
                        state_r <= S_C2;
                    end
                    `CLS_AREAD, `CLS_AWRITE: begin
                        DM_ADDR <= ir2_r;
                        dst_r   <= f_d;
                        pcn_r   <= pc_r + 16'h0002;
                        if (cls == `CLS_AWRITE) begin
                            DM_WDATA <= regs[f_d];
                            DM_WE    <= 1'b1;
                        end else begin
                            DM_RE    <= 1'b1;
                        end
                        state_r <= S_C2;
                    end
                    `CLS_CODE: begin
                        PM_ADDR <= zval;
                        PM_RE   <= 1'b1;
                        dst_r   <= f_d;
                        if (f_cinc) begin
                            regs[zb]        <= zinc[7:0];
                            regs[zb + 5'h1] <= zinc[15:8];
                        end
                        state_r <= S_C2;
                    end
                    default: begin
                        illegal_r  <= 1'b1;
                        pc_r       <= pc_r + 16'h0001;
                        state_r    <= S_IDLE;
                        BUSY       <= 1'b0;
                        last_cyc_r <= `CYC_ONE;
                    end
                endcase
            end
            S_C2: begin
                cyc_r <= cyc_r + 2'h1;
                if (cls == `CLS_CODE) begin
                    state_r <= S_C3;
                end else begin
                    if (DM_RE) begin
                        regs[dst_r] <= DM_RDATA;
                    end
                    DM_RE      <= 1'b0;
                    DM_WE      <= 1'b0;
                    pc_r       <= pcn_r;
                    state_r    <= S_IDLE;
                    BUSY       <= 1'b0;
                    last_cyc_r <= `CYC_TWO;
                end
            end
            S_C3: begin
                cyc_r       <= cyc_r + 2'h1;
                regs[dst_r] <= PM_RDATA;
                PM_RE       <= 1'b0;
                pc_r        <= pcn_r;
                state_r     <= S_IDLE;
                BUSY        <= 1'b0;
                last_cyc_r  <= `CYC_THREE;
            end
            default: begin
            end
        endcase
    end
end

// Branch aliases on the generic flag test:
// equal/not-equal on Z
// carry set/lower, clear/higher
// negative/positive on N
// half-carry on H
// user bit on T
// interrupt state on I
// No instruction here writes flags_r; only the bus does.

endmodule

// ==== bench/exec_checker.sv ====
// Port assertions for the branch and load/store execution unit
`timescale 1ns/1ps
`include "exec_map.vh"

module exec_checker (
    input wire       MCLK,
    input wire       NRST,
    input wire       PSEL,
    input wire       PENABLE,
    input wire       PWRITE,
    input wire [7:0] PADDR,
    input wire       PREADY,
    input wire       PSLVERR,
    input wire       DM_WE,
    input wire       DM_RE,
    input wire       PM_RE,
    input wire       BUSY
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    ////////////////////////////////////////////////////////////////////////
    sequence insn_taken;
        PSEL && PENABLE && PREADY && PWRITE && PADDR == `OFS_INSN && !PSLVERR;
    endsequence
    sequence done_s(sig);
        !sig && !BUSY;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    apb_ready_a: assert property (PSEL && $rose(PENABLE) |=> PREADY ##1 !PREADY)
        else $error("access phase length wrong");
    insn_start_a: assert property (insn_taken |=> BUSY)
        else $error("execution did not start");
    store_pulse_a: assert property ($rose(DM_WE) |-> BUSY && $past(BUSY) ##1 done_s(DM_WE))
        else $error("store strobe timing wrong");
    load_pulse_a: assert property ($rose(DM_RE) |-> BUSY && $past(BUSY) ##1 done_s(DM_RE))
        else $error("load strobe timing wrong");
    code_read_a: assert property ($rose(PM_RE) |=> PM_RE ##1 done_s(PM_RE))
        else $error("code read timing wrong");
    strobe_excl_a: assert property (!(DM_WE && DM_RE) && !(PM_RE && (DM_WE || DM_RE)))
        else $error("memory strobes overlap");
    strobe_busy_a: assert property ((DM_WE || DM_RE || PM_RE) |-> BUSY)
        else $error("strobe outside execution");
    busy_bound_a: assert property ($rose(BUSY) |-> ##[1:3] !BUSY)
        else $error("execution too long");
endmodule

bind cond_branch_and_load_store exec_checker chk_i (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .DM_WE(DM_WE), .DM_RE(DM_RE),
    .PM_RE(PM_RE), .BUSY(BUSY));

// ==== bench/mem_model.sv ====
// Data and code memory model beside the execution unit
`timescale 1ns/1ps

module mem_model (
    input  wire        mclk,
    input  wire [15:0] dm_addr,
    input  wire [7:0]  dm_wdata,
    input  wire        dm_we,
    input  wire        dm_re,
    output logic [7:0] dm_rdata,
    input  wire [15:0] pm_addr,
    input  wire        pm_re,
    output logic [7:0] pm_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] code;

    initial begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'(i ^ (i >> 8)) ^ 8'h3c;
    end
    // Write lands at the edge ending the strobe cycle
    always @(posedge mclk) begin
        if (dm_we)
            mem[dm_addr] <= dm_wdata;
    end
    // Outside a strobe the data lines show inverted garbage
    assign code = pm_addr[7:0] + pm_addr[15:8] + 8'h11;
    assign dm_rdata = dm_re ? mem[dm_addr] : ~mem[dm_addr];
    assign pm_rdata = pm_re ? code : ~code;
endmodule

// ==== bench/tb_top.sv ====
// Self-checking testbench for the execution unit
`timescale 1ns/1ps
`include "exec_map.vh"

module tb_top;
    logic        MCLK = 1'h0, NRST = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic        PREADY, PSLVERR, DM_WE, DM_RE, PM_RE, BUSY, err;
    logic [15:0] DM_ADDR, PM_ADDR, ptr, base, post, ea, e;
    logic [7:0]  DM_WDATA, DM_RDATA, PM_RDATA, f, v;
    logic [6:0]  k;
    logic [5:0]  q;
    int          num_errors = 0, n_checks = 0;

    always #20 MCLK = ~MCLK;

    cond_branch_and_load_store uut (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .DM_ADDR(DM_ADDR), .DM_WDATA(DM_WDATA), .DM_WE(DM_WE), .DM_RE(DM_RE), .DM_RDATA(DM_RDATA),
        .PM_ADDR(PM_ADDR), .PM_RE(PM_RE), .PM_RDATA(PM_RDATA), .BUSY(BUSY));
    mem_model mem_i (.mclk(MCLK), .dm_addr(DM_ADDR), .dm_wdata(DM_WDATA), .dm_we(DM_WE), .dm_re(DM_RE),
        .dm_rdata(DM_RDATA), .pm_addr(PM_ADDR), .pm_re(PM_RE), .pm_rdata(PM_RDATA));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'h1;
        do begin
            @(posedge MCLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask

    task setr(input int i, input logic [7:0] d);
        apb(1'h1, `OFS_REGSEL, 32'(i));
        apb(1'h1, `OFS_REGDATA, {24'h0, d});
    endtask

    task getr(input int i);
        apb(1'h1, `OFS_REGSEL, 32'(i));
        apb(1'h0, `OFS_REGDATA, 32'h0);
    endtask

    task setp(input int p, input logic [15:0] d);
        setr(26 + 2 * p, d[7:0]);
        setr(27 + 2 * p, d[15:8]);
    endtask

    task getp(input int p);
        getr(26 + 2 * p);
        ptr[7:0] = rd[7:0];
        getr(27 + 2 * p);
        ptr[15:8] = rd[7:0];
    endtask

    // Runs one instruction and leaves the status word in rd
    task exec(input logic [15:0] insn);
        apb(1'h1, `OFS_INSN, {16'h0, insn});
        do begin
            @(posedge MCLK);
        end while (BUSY !== 1'b0);
        apb(1'h0, `OFS_STATUS, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge MCLK);
        NRST <= 1'h1;
        for (int b = 0; b < 8; b++)
            for (int s = 0; s < 2; s++)
                for (int t = 0; t < 2; t++) begin
                    f = (b == 4) ? (t ? 8'h08 : 8'h0c) : 8'(t << b);
                    k = s ? 7'h7d : 7'h05;
                    e = (t == s) ? 16'h0011 + {{9{k[6]}}, k} : 16'h0011;
                    apb(1'h1, `OFS_PC, 32'h0010);
                    apb(1'h1, `OFS_FLAGS, {24'h0, f});
                    exec({4'h0, s[0], b[2:0], 1'h0, k});
                    chk(rd[3:1], (t == s) ? 3'h6 : 3'h1);
                    apb(1'h0, `OFS_PC, 32'h0);
                    chk(rd, {16'h0, e});
                    apb(1'h0, `OFS_FLAGS, 32'h0);
                    chk(rd, {24'h0, f});
                end
        apb(1'h1, `OFS_FLAGS, 32'ha5);
        setr(1, 8'h5a);
        setr(0, 8'h96);
        exec(16'h1061);
        chk(rd[2:1], 2'h1);
        exec(16'h2020);
        exec(16'h3f7e);
        getr(3);
        chk(rd, 32'h5a);
        getr(4);
        chk(rd, 32'h96);
        getr(5);
        chk(rd, 32'h5a);
        getr(31);
        chk(rd, 32'h7e);
        apb(1'h0, `OFS_FLAGS, 32'h0);
        chk(rd, 32'ha5);
        for (int c = 4; c < 6; c++)
            for (int p = 0; p < 3; p++)
                for (int m = 0; m < 3; m++) begin
                    base = m == 0 ? 16'h1234 : m == 1 ? 16'h12ff : 16'h0000;
                    post = m == 1 ? base + 16'h1 : m == 2 ? base - 16'h1 : base;
                    ea = m == 2 ? post : base;
                    v = 8'hc0 + 8'(p * 3 + m);
                    setp(p, base);
                    setr(3, v);
                    exec({4'(c), 2'(p), 2'(m), 3'h0, 5'(c - 2)});
                    chk(rd[2:1], 2'h2);
                    getp(p);
                    chk(ptr, post);
                    getr(2);
                    chk(c == 4 ? rd[7:0] : mem_i.mem[ea], c == 4 ? pat(ea) : v);
                end
        for (int c = 6; c < 8; c++)
            for (int z = 0; z < 2; z++) begin
                q = z ? 6'h01 : 6'h3f;
                ea = 16'h2000 + q;
                setp(z + 1, 16'h2000);
                setr(3, {2'h1, q});
                exec({4'(c), z[0], q, 5'(c - 4)});
                chk(rd[2:1], 2'h2);
                getp(z + 1);
                chk(ptr, 16'h2000);
                getr(2);
                chk(c == 6 ? rd[7:0] : mem_i.mem[ea], c == 6 ? pat(ea) : {2'h1, q});
            end
        apb(1'h1, `OFS_PC, 32'h0040);
        apb(1'h1, `OFS_INSN2, 32'hbeef);
        exec(16'h8007);
        chk(rd[2:1], 2'h2);
        apb(1'h0, `OFS_PC, 32'h0);
        chk(rd, 32'h42);
        getr(7);
        chk(rd, {24'h0, pat(16'hbeef)});
        apb(1'h1, `OFS_INSN2, 32'h4321);
        setr(3, 8'h77);
        exec(16'h9003);
        chk(mem_i.mem[16'h4321], 8'h77);
        setp(2, 16'h03ff);
        exec(16'ha109);
        chk(rd[2:1], 2'h3);
        getr(9);
        chk(rd, 32'h13);
        getp(2);
        chk(ptr, 16'h0400);
        apb(1'h1, `OFS_STATUS, 32'h0);
        chk(err, 1'h1);
        apb(1'h0, 8'h1c, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'h1);
        exec(16'h4c02);
        chk(rd[4:1], 4'h9);
        end_of_test;
    end

    initial begin
        repeat (40000) @(posedge MCLK);
        num_errors++;
        end_of_test;
    end
endmodule
